// File: core/flag_exec_consts.svh
`ifndef FLAG_EXEC_CONSTS_SVH
`define FLAG_EXEC_CONSTS_SVH

// Bit positions inside the status flags register
`define BIT_CARRY      3'h0
`define BIT_ZERO       3'h1
`define BIT_NEGATIVE   3'h2
`define BIT_OVERFLOW   3'h3
`define BIT_SIGNED     3'h4
`define BIT_HALF_CARRY 3'h5
`define BIT_TRANSFER   3'h6
`define BIT_INT_EN     3'h7

// Register offsets on the plain register port
`define ADDR_FLAGS     4'h0
`define ADDR_CTRL      4'h1
`define ADDR_LAST_OP   4'h2
`define ADDR_OP_COUNT  4'h3

// Reset values
`define FLAGS_RESET    8'h00
`define CTRL_RESET     8'h01
`define LAST_OP_RESET  8'h00
`define COUNT_RESET    8'h00

// Control register field: execution enable
`define CTRL_EXEC_EN   3'h0

// Instruction word class codes, held in bits 15..8
`define CLASS_FLAG_SET 8'hA1
`define CLASS_FLAG_CLR 8'hA2
`define CLASS_SLEEP    8'hA3
`define CLASS_WDR      8'hA4

// Execute time of every flag instruction, in core cycles
`define EXEC_CYCLES    1

`endif

// File: core/flag_exec_pkg.sv
package flag_exec_pkg;

  // Kinds of instruction this block acts on
  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_SET   = 3'h1,
    OP_CLR   = 3'h3,
    OP_SLEEP = 3'h2,
    OP_WDR   = 3'h6
  } op_kind_e;

  // Decoded instruction
  typedef struct packed {
    op_kind_e   kind;
    logic [2:0] bitSel;
  } flag_op_s;

endpackage

// File: core/flag_op_decode.sv
`timescale 1ns/1ps
`include "flag_exec_consts.svh"

module flag_op_decode
  import flag_exec_pkg::*;
(
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  output flag_op_s         op
);

  // Class byte picks the kind; low three bits pick the flag
  always_comb begin
    op.bitSel = instrWord[2:0];
    op.kind   = OP_NONE;
    if (instrValid) begin
      case (instrWord[15:8])
        `CLASS_FLAG_SET: op.kind = OP_SET;
        `CLASS_FLAG_CLR: op.kind = OP_CLR;
        `CLASS_SLEEP:    op.kind = OP_SLEEP;
        `CLASS_WDR:      op.kind = OP_WDR;
        default:         op.kind = OP_NONE; // Not ours, no effect
      endcase
    end
  end

endmodule

// File: core/status_flag_instruction_exec.sv
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "flag_exec_consts.svh"

// Overview of operation
// - Clear-negative clears N, set-zero sets Z, clear-zero clears Z; one cycle.
// - Interrupt-enable op sets the interrupt-enable flag in one cycle.
// - Interrupt-disable op clears only the interrupt-enable flag in one cycle.
// - Set and clear signed ops change only the signed flag, one cycle.
// - Set and clear overflow ops change only the overflow flag, one cycle.
// - Set-transfer op sets the transfer bit and touches no other flag.
// - Clear-half-carry op clears only the half-carry flag in one cycle.
// - Sleep op takes one cycle, keeps all flags, requests sleep mode.
// - Watchdog-restart op takes one cycle, keeps flags, restarts watchdog.

module status_flag_instruction_exec
  import flag_exec_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  output logic      [7:0]  statusFlags,
  output logic             intEnable,
  output logic             sleepRequest,
  output logic             watchdogRestart
);

  flag_op_s   op;
  logic [7:0] ctrl;
  logic [7:0] lastOp;
  logic [7:0] opCount;
  logic       execOn;
  logic       setOp;
  logic       clrOp;
  logic [7:0] setMask;
  logic [7:0] clrMask;
  logic [7:0] baseFlags;
  logic [7:0] opFlags;
  logic [7:0] next_statusFlags;
  logic [7:0] next_ctrl;
  logic [7:0] next_lastOp;
  logic [7:0] next_opCount;
  logic [7:0] next_regRdData;
  logic       next_sleepRequest;
  logic       next_watchdogRestart;

  // One-hot mask of a flag position
  function automatic logic [7:0] bitMask(input logic [2:0] sel);
    bitMask = 8'h01 << sel;
  endfunction

  flag_op_decode decode (
    .instrValid (instrValid),
    .instrWord  (instrWord),
    .op         (op)
  );

  // Software can halt execution here, e.g. while patching flags
  assign execOn  = ctrl[`CTRL_EXEC_EN];
  assign setOp   = execOn && (op.kind == OP_SET);
  assign clrOp   = execOn && (op.kind == OP_CLR);
  assign setMask = setOp ? bitMask(op.bitSel) : 8'h00;
  assign clrMask = clrOp ? bitMask(op.bitSel) : 8'h00;

  // Bus write first, so an instruction in the same cycle wins its bit
  assign baseFlags = (regWrite && regAddr == `ADDR_FLAGS) ?
                     regWrData : statusFlags;

  // Each flag: set mask, else clear mask, else keep the base value
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      assign opFlags[gi] = setMask[gi] ? 1'b1 :
                           clrMask[gi] ? 1'b0 :
                           baseFlags[gi];
    end
  endgenerate

  assign intEnable = statusFlags[`BIT_INT_EN];

  // Next state of flags, control, trace and pulses
  always_comb begin
    next_statusFlags     = opFlags;
    next_ctrl            = ctrl;
    next_lastOp          = lastOp;
    next_opCount         = opCount;
    next_sleepRequest    = execOn && (op.kind == OP_SLEEP);
    next_watchdogRestart = execOn && (op.kind == OP_WDR);
    next_regRdData       = 8'h00;
    if (regWrite && regAddr == `ADDR_CTRL) begin
      next_ctrl = {7'h00, regWrData[`CTRL_EXEC_EN]};
    end
    if (execOn && op.kind != OP_NONE) begin
      next_lastOp  = {2'h0, op.kind, op.bitSel};
      next_opCount = opCount + 8'h01;   // Wraps at 255
    end
    if (regRead) begin
      case (regAddr)
        `ADDR_FLAGS:    next_regRdData = statusFlags;
        `ADDR_CTRL:     next_regRdData = ctrl;
        `ADDR_LAST_OP:  next_regRdData = lastOp;
        `ADDR_OP_COUNT: next_regRdData = opCount;
        default:        next_regRdData = 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // Registers only; every update lands at the end of the execute cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      statusFlags     <= `FLAGS_RESET;
      ctrl            <= `CTRL_RESET;
      lastOp          <= `LAST_OP_RESET;
      opCount         <= `COUNT_RESET;
      regRdData       <= 8'h00;
      sleepRequest    <= 1'b0;
      watchdogRestart <= 1'b0;
    end else begin
      statusFlags     <= next_statusFlags;
      ctrl            <= next_ctrl;
      lastOp          <= next_lastOp;
      opCount         <= next_opCount;
      regRdData       <= next_regRdData;
      sleepRequest    <= next_sleepRequest;
      watchdogRestart <= next_watchdogRestart;
    end
  end

  // Checks on the executed flag instructions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  logic noWr;
  assign noWr = !(regWrite && regAddr == `ADDR_FLAGS);

  sequence clrBit(logic [2:0] b);
    clrOp && op.bitSel == b;
  endsequence

  sequence setBit(logic [2:0] b);
    setOp && op.bitSel == b;
  endsequence

  neg_zero_ops_a: assert property (
    (clrBit(`BIT_NEGATIVE) |=> !statusFlags[`BIT_NEGATIVE]) and
    (setBit(`BIT_ZERO) |=> statusFlags[`BIT_ZERO]) and
    (clrBit(`BIT_ZERO) |=> !statusFlags[`BIT_ZERO]))
    else $error("negative or zero flag op not applied");

  int_enable_set_a: assert property (
    setBit(`BIT_INT_EN) |=> intEnable && statusFlags[`BIT_INT_EN])
    else $error("interrupt enable not set");

  int_disable_only_a: assert property (
    clrBit(`BIT_INT_EN) && noWr |=>
      !intEnable &&
      statusFlags[6:0] == $past(statusFlags[6:0]))
    else $error("interrupt disable wrong or touched other flags");

  signed_flag_only_a: assert property (
    (setOp || clrOp) && op.bitSel == `BIT_SIGNED && noWr |=>
      statusFlags[`BIT_SIGNED] == $past(setOp) &&
      (statusFlags ^ $past(statusFlags)) == 8'h10 ||
      statusFlags == $past(statusFlags))
    else $error("signed flag op wrong");

  overflow_flag_only_a: assert property (
    (setOp || clrOp) && op.bitSel == `BIT_OVERFLOW && noWr |=>
      statusFlags[`BIT_OVERFLOW] == $past(setOp) &&
      (statusFlags & 8'hF7) == ($past(statusFlags) & 8'hF7))
    else $error("overflow flag op wrong");

  transfer_set_a: assert property (
    setBit(`BIT_TRANSFER) && noWr |=>
      statusFlags[`BIT_TRANSFER] &&
      (statusFlags & 8'hBF) == ($past(statusFlags) & 8'hBF))
    else $error("transfer bit op wrong");

  half_carry_clr_a: assert property (
    clrBit(`BIT_HALF_CARRY) && noWr |=>
      !statusFlags[`BIT_HALF_CARRY] &&
      (statusFlags & 8'hDF) == ($past(statusFlags) & 8'hDF))
    else $error("half carry clear wrong");

  sleep_one_cycle_a: assert property (
    execOn && op.kind == OP_SLEEP && noWr |=>
      sleepRequest && statusFlags == $past(statusFlags) ##1
      (sleepRequest == $past(execOn && op.kind == OP_SLEEP)))
    else $error("sleep op wrong");

  wdt_restart_a: assert property (
    execOn && op.kind == OP_WDR && noWr |=>
      watchdogRestart && !sleepRequest &&
      statusFlags == $past(statusFlags))
    else $error("watchdog restart op wrong");

  next_instr_sees_a: assert property (
    setOp ##1 clrOp && op.bitSel != $past(op.bitSel) && noWr |=>
      statusFlags[$past(op.bitSel, 2)])
    else $error("earlier flag update lost by next instruction");

  halted_no_effect_a: assert property (
    !execOn && noWr |=> statusFlags == $past(statusFlags) &&
      !sleepRequest && !watchdogRestart)
    else $error("op executed while disabled");

  cov_set_then_clr: cover property (setOp ##1 clrOp);
  cov_sleep:        cover property (execOn && op.kind == OP_SLEEP);
  cov_wdr:          cover property (execOn && op.kind == OP_WDR);
  cov_wr_and_op:    cover property (!noWr && (setOp || clrOp));

endmodule

// File: verif/tb_status_flag_instruction_exec.sv
`timescale 1ns/1ps
`include "flag_exec_consts.svh"

module tb_status_flag_instruction_exec;
  logic        ref_clk;
  logic        arst_n;
  logic        instrValid;
  logic [15:0] instrWord;
  logic [3:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWrite;
  logic        regRead;
  logic [7:0]  regRdData;
  logic [7:0]  statusFlags;
  logic        intEnable;
  logic        sleepRequest;
  logic        watchdogRestart;
  logic [31:0] r;
  logic [3:0]  a;
  logic [7:0]  clear_signed_op [5];
  int          errors;
  int          tests_run;
  int          seed;
  int          mFlags;
  int          mEn;
  int          mCnt;
  int          expRd;
  int          expSlp;
  int          expWdr;
  int          i;

  status_flag_instruction_exec dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .instrValid(instrValid),
    .instrWord(instrWord), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .statusFlags(statusFlags), .intEnable(intEnable),
    .sleepRequest(sleepRequest), .watchdogRestart(watchdogRestart));

  // Free-running core clock
  always #5 ref_clk = ~ref_clk;

  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask

  // Registered read: value before this edge's updates
  function automatic int rdval(input logic [3:0] ad);
    case (ad)
      `ADDR_FLAGS:    return mFlags;
      `ADDR_CTRL:     return mEn;
      `ADDR_OP_COUNT: return mCnt;
      default:        return 0;
    endcase
  endfunction

  // One core cycle: drive, check last cycle's results, advance the model
  task automatic cyc(input logic v, input logic [15:0] w, input logic wr,
                     input logic rd, input logic [3:0] ad,
                     input logic [7:0] d);
    int oldEn;
    @(posedge ref_clk);
    instrValid <= v;
    instrWord  <= w;
    regWrite   <= wr;
    regRead    <= rd;
    regAddr    <= ad;
    regWrData  <= d;
    #1;
    chk8("statusFlags", 8'(mFlags), statusFlags);
    chk1("intEnable", mFlags[7], intEnable);
    chk1("sleepRequest", expSlp[0], sleepRequest);
    chk1("watchdogRestart", expWdr[0], watchdogRestart);
    chk8("regRdData", 8'(expRd), regRdData);
    expRd  = rd ? rdval(ad) : 0;
    oldEn  = mEn;
    expSlp = 0;
    expWdr = 0;
    if (wr && ad == `ADDR_FLAGS) mFlags = d;
    if (wr && ad == `ADDR_CTRL) mEn = d[0];
    // The op sees the enable as it was before this edge
    if (v && oldEn[0]) begin
      case (w[15:8])
        `CLASS_FLAG_SET: mFlags[w[2:0]] = 1'b1;
        `CLASS_FLAG_CLR: mFlags[w[2:0]] = 1'b0;
        `CLASS_SLEEP:    expSlp = 1;
        `CLASS_WDR:      expWdr = 1;
        default:         oldEn = 0;
      endcase
      if (oldEn[0]) mCnt = (mCnt + 1) & 255;
    end
  endtask

  task automatic end_of_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  initial begin
    ref_clk = 0; arst_n = 0; instrValid = 0; instrWord = 0;
    regAddr = 0; regWrData = 0; regWrite = 0; regRead = 0;
    seed = 32'hA4E1; errors = 0; tests_run = 0;
    mFlags = 0; mEn = 1; mCnt = 0; expRd = 0; expSlp = 0; expWdr = 0;
    clear_signed_op = '{`CLASS_FLAG_SET, `CLASS_FLAG_CLR, `CLASS_SLEEP, `CLASS_WDR,
            8'h5A};
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    // Reset values of flags and control
    cyc(0, 16'h0000, 0, 1, `ADDR_FLAGS, 8'h00);
    cyc(0, 16'h0000, 0, 1, `ADDR_CTRL, 8'h00);
    // Every flag set then cleared, back to back, neighbours watched
    for (i = 0; i < 8; i++) cyc(1, {`CLASS_FLAG_SET, 5'h1F, 3'(i)}, 0, 0, 0, 0);
    for (i = 0; i < 8; i++) cyc(1, {`CLASS_FLAG_CLR, 5'h00, 3'(i)}, 0, 0, 0, 0);
    // Sleep and watchdog back to back keep all flags
    cyc(1, {`CLASS_SLEEP, 8'h00}, 0, 0, 0, 0);
    cyc(1, {`CLASS_WDR, 8'h00}, 0, 0, 0, 0);
    cyc(1, {`CLASS_SLEEP, 8'h00}, 0, 0, 0, 0);
    cyc(1, 16'h5507, 0, 0, 0, 0);
    // Bus write and op together: op wins its bit only
    cyc(1, {`CLASS_FLAG_CLR, 8'h02}, 1, 0, `ADDR_FLAGS, 8'h55);
    cyc(0, 16'h0000, 1, 0, `ADDR_LAST_OP, 8'hFF);
    cyc(0, 16'h0000, 1, 0, `ADDR_OP_COUNT, 8'hFF);
    for (i = 0; i < 16; i++) if (i != 2) cyc(0, 0, 0, 1, 4'(i), 0);
    // Execution disabled: ops refused
    cyc(0, 16'h0000, 1, 0, `ADDR_CTRL, 8'hFE);
    cyc(1, {`CLASS_FLAG_SET, 8'h07}, 0, 1, `ADDR_CTRL, 0);
    cyc(0, 16'h0000, 1, 0, `ADDR_CTRL, 8'h01);
    // Random mix of ops and bus traffic; last-op register not modelled
    for (i = 0; i < 400; i++) begin
      r = $random(seed);
      a = r[11:8];
      if (a == `ADDR_LAST_OP) a = `ADDR_OP_COUNT;
      cyc(r[0], {clear_signed_op[r[6:4] % 5], r[23:16]}, r[1] & ~r[2], r[2], a,
          r[31:24]);
    end
    cyc(0, 16'h0000, 0, 1, `ADDR_OP_COUNT, 8'h00);
    cyc(0, 16'h0000, 0, 0, 0, 0);
    end_of_test();
  end
endmodule
